// ---- core/rrx_defs.vh ----
// constants for the return and rotate execution block
`ifndef RRX_DEFS_VH
`define RRX_DEFS_VH
`define RRX_OPC_W          14
`define RRX_RETLIT_MASK    14'h3c00
`define RRX_RETLIT_MATCH   14'h3400
`define RRX_RETURN_CODE    14'h0008
`define RRX_ROT_MASK       14'h3f00
`define RRX_ROT_MATCH      14'h0c00
`define RRX_DEST_BIT       7
`define RRX_PC_W           11
`define RRX_FADDR_W        7
`define RRX_W_RST          8'h00
`define RRX_CARRY_RST      1'b0
`define RRX_PC_RST         11'h000
`define RRX_RET_CYCLES     2
`endif

// ---- core/rrx_core.v ----
// execution of return with literal, return and rotate right through carry
// How it works
// - return with literal loads the low eight opcode bits into the working register
// - return with literal pops stack top into pc, takes two cycles
// - return with literal changes no flag; any literal 0 to 255 is accepted
// - rotate right: old carry enters bit 7, bit 0 becomes carry, only carry changes
// - rotate with destination 0 writes working register, source register untouched
// - rotate with destination 1 writes source register back, one cycle
`default_nettype none
`include "rrx_defs.vh"
module rrx_core (
  input  wire                      sys_clk_in,
  input  wire                      rst_n_in,
  input  wire                      instr_valid_in,
  input  wire [`RRX_OPC_W-1:0]     instr_in,
  input  wire [`RRX_PC_W-1:0]      stack_top_in,
  input  wire [7:0]                file_data_in,
  output reg  [7:0]                w_out,
  output reg                       carry_out,
  output reg  [`RRX_PC_W-1:0]      pc_out,
  output reg                       pc_load_out,
  output reg                       stack_pop_out,
  output reg                       busy_out,
  output reg                       file_we_out,
  output reg  [`RRX_FADDR_W-1:0]   file_addr_out,
  output reg  [7:0]                file_wdata_out
);

  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  // opcode classes, shared by the control and the datapath decode
  function is_ret_lit;
    input [`RRX_OPC_W-1:0] opc;
    begin
      is_ret_lit = ((opc & `RRX_RETLIT_MASK) == `RRX_RETLIT_MATCH);
    end
  endfunction

  function is_plain_ret;
    input [`RRX_OPC_W-1:0] opc;
    begin
      is_plain_ret = (opc == `RRX_RETURN_CODE);
    end
  endfunction

  function is_rot_right;
    input [`RRX_OPC_W-1:0] opc;
    begin
      is_rot_right = ((opc & `RRX_ROT_MASK) == `RRX_ROT_MATCH);
    end
  endfunction

  // both return forms pop the stack the same way
  function is_pop_class;
    input [`RRX_OPC_W-1:0] opc;
    begin
      is_pop_class = is_ret_lit(opc) || is_plain_ret(opc);
    end
  endfunction

  reg                      state;
  reg                      next_state;
  reg [7:0]                next_w;
  reg                      next_carry;
  reg [`RRX_PC_W-1:0]      next_pc;
  reg                      next_pc_load;
  reg                      next_stack_pop;
  reg                      next_busy;
  reg                      next_file_we;
  reg [`RRX_FADDR_W-1:0]   next_file_addr;
  reg [7:0]                next_file_wdata;

  wire                     take;
  wire                     take_pop;
  wire                     take_rot;
  wire                     dest_file;
  wire [7:0]               rot_val;

  // opcodes are only taken in idle; the second return cycle is a flush slot
  assign take      = instr_valid_in && (state == ST_IDLE);
  assign take_pop  = take && is_pop_class(instr_in);
  assign take_rot  = take && is_rot_right(instr_in);
  assign dest_file = instr_in[`RRX_DEST_BIT];

  // old carry enters the top, every other bit moves down one place
  assign rot_val[7] = carry_out;

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_rot
      assign rot_val[gi] = file_data_in[gi+1];
    end
  endgenerate

  always @* begin
    next_state      = state;
    next_w          = w_out;
    next_carry      = carry_out;
    next_pc         = pc_out;
    next_pc_load    = 1'b0;
    next_stack_pop  = 1'b0;
    next_busy       = 1'b0;
    next_file_we    = 1'b0;
    next_file_addr  = file_addr_out;
    next_file_wdata = file_wdata_out;
    case (state)
      ST_IDLE: begin
        if (take_pop) begin
          // literal only for the loading form; plain return keeps w
          if (is_ret_lit(instr_in)) begin
            next_w = instr_in[7:0];
          end
          next_pc        = stack_top_in;
          next_pc_load   = 1'b1;
          next_stack_pop = 1'b1;
          next_busy      = 1'b1;
          next_state     = ST_WAIT;
        end else if (take_rot) begin
          next_carry = file_data_in[0];
          if (dest_file) begin
            next_file_we    = 1'b1;
            next_file_addr  = instr_in[`RRX_FADDR_W-1:0];
            next_file_wdata = rot_val;
          end else begin
            next_w = rot_val;
          end
        end
      end
      ST_WAIT: begin
        // whatever is fetched in the flush slot is dropped
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      w_out <= `RRX_W_RST;
    end else begin
      w_out <= next_w;
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      carry_out <= `RRX_CARRY_RST;
    end else begin
      carry_out <= next_carry;
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pc_out <= `RRX_PC_RST;
    end else begin
      pc_out <= next_pc;
    end
  end

  // strobes are single-cycle pulses; the core must not rely on them lasting
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pc_load_out <= 1'b0;
    end else begin
      pc_load_out <= next_pc_load;
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      stack_pop_out <= 1'b0;
    end else begin
      stack_pop_out <= next_stack_pop;
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= next_busy;
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      file_we_out <= 1'b0;
    end else begin
      file_we_out <= next_file_we;
    end
  end

  // address and data hold after the write so a slow file can still latch them
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      file_addr_out <= {`RRX_FADDR_W{1'b0}};
    end else begin
      file_addr_out <= next_file_addr;
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      file_wdata_out <= 8'h00;
    end else begin
      file_wdata_out <= next_file_wdata;
    end
  end

endmodule // rrx_core
`default_nettype wire

// ---- testbench/rrx_properties.sv ----
// checker for return and rotate execution
`default_nettype none
module rrx_props(input wire logic sys_clk_in, rst_n_in, instr_valid_in, busy_out, carry_out,
  pc_load_out, stack_pop_out, file_we_out, input wire logic [13:0] instr_in,
  input wire logic [10:0] stack_top_in, pc_out, input wire logic [7:0] file_data_in, w_out,
  file_wdata_out, input wire logic [6:0] file_addr_out);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire t = instr_valid_in & !busy_out, l = t & instr_in[13:10] == 4'hd;
  wire n = t & instr_in == 14'h8, p = l | n, o = t & instr_in[13:8] == 6'hc, d = instr_in[7];
  wire [7:0] v = {carry_out, file_data_in[7:1]};
  AST_R1: assert property (l |=> w_out == $past(instr_in[7:0])) else $error("w");
  AST_R2: assert property (p |=> busy_out & pc_load_out & stack_pop_out
    & pc_out == $past(stack_top_in) ##1 !pc_load_out) else $error("pop");
  AST_R3: assert property (p |=> $stable(carry_out)) else $error("flag");
  AST_R4: assert property (o |=> carry_out == $past(file_data_in[0])) else $error("c");
  AST_R5: assert property (o & !d |=> w_out == $past(v) & !file_we_out) else $error("rw");
  AST_R6: assert property (o & d |=> file_we_out & file_wdata_out == $past(v)
    & file_addr_out == $past(instr_in[6:0]) & $stable(w_out)) else $error("rf");
  AST_R7: assert property (n |=> $stable(w_out)) else $error("ret");
  cover property (l);
  cover property (o & d);
  cover property (o & !d);
  cover property (n);
endmodule // rrx_props
bind rrx_core rrx_props u_props (.*);
`default_nettype wire

// ---- testbench/test_return_and_rotate_execution.sv ----
// bench for return and rotate execution
`default_nettype none
module test_return_and_rotate_execution;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk_in     = 1'b0;
  logic        rst_n_in       = 1'b0;
  logic        instr_valid_in = 1'b0;
  logic        c              = 1'b0;
  logic [13:0] instr_in       = 14'h0000;
  logic [10:0] stack_top_in   = 11'h000;
  logic [7:0]  file_data_in   = 8'h00;
  logic [7:0]  w              = 8'h00;
  wire  [7:0]  w_out;
  wire  [7:0]  file_wdata_out;
  wire  [10:0] pc_out;
  wire  [6:0]  file_addr_out;
  wire         carry_out;
  wire         pc_load_out;
  wire         stack_pop_out;
  wire         busy_out;
  wire         file_we_out;
  logic [15:0] r              = 16'h6e7f; // seed 28287
  logic [8:0]  x;
  int          fail_count     = 0;
  int          comparisons    = 0;
  rrx_core uut (
    .sys_clk_in     (sys_clk_in),
    .rst_n_in       (rst_n_in),
    .instr_valid_in (instr_valid_in),
    .instr_in       (instr_in),
    .stack_top_in   (stack_top_in),
    .file_data_in   (file_data_in),
    .w_out          (w_out),
    .carry_out      (carry_out),
    .pc_out         (pc_out),
    .pc_load_out    (pc_load_out),
    .stack_pop_out  (stack_pop_out),
    .busy_out       (busy_out),
    .file_we_out    (file_we_out),
    .file_addr_out  (file_addr_out),
    .file_wdata_out (file_wdata_out)
  );
  initial begin
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [8:0] rot(input logic cy, input logic [7:0] f);
    return {f[0], cy, f[7:1]};
  endfunction
  task automatic chk(input string n, input logic [10:0] s, input logic [10:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task stop_test;
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk_in);
    #1;
    chk("w_rst", w_out, 8'h00);
    chk("c_rst", carry_out, 1'b0);
    chk("pc_rst", pc_out, 11'h000);
    chk("busy_rst", busy_out, 1'b0);
    rst_n_in = 1'b1;
    for (int i = 0; i < 400; i++) begin
      r = lfsr_next(r);
      {stack_top_in, file_data_in} = {r[10:0], r[15:8]};
      // idle cycles: an opcode without valid must change nothing
      instr_valid_in = (i < 8) || (r[14:12] != 3'd0);
      x = rot(c, file_data_in);
      // literal corners 00 and ff first, then random mix
      case (i < 2 ? 2'd0 : r[1:0])
        0: instr_in = {4'hd, r[3:2], i < 2 ? {8{i[0]}} : r[11:4]};
        1: instr_in = 14'h0008;
        default: instr_in = {6'h0c, r[2], r[9:3]};
      endcase
      @(posedge sys_clk_in);
      #1;
      if (!instr_valid_in) begin
        chk("idle_we", file_we_out, 1'b0);
        chk("idle_pop", stack_pop_out, 1'b0);
        chk("idle_load", pc_load_out, 1'b0);
      end else if (instr_in[13:11] == 3'b001) begin
        c = x[8];
        if (!instr_in[7]) begin
          w = x[7:0];
        end else begin
          chk("wdata", file_wdata_out, x[7:0]);
          chk("addr", file_addr_out, instr_in[6:0]);
        end
        chk("we", file_we_out, instr_in[7]);
      end else begin
        if (instr_in[13]) begin
          w = instr_in[7:0];
        end
        chk("pc", pc_out, stack_top_in);
        chk("load", pc_load_out, 1'b1);
        chk("pop1", stack_pop_out, 1'b1);
        chk("busy", busy_out, 1'b1);
        // dead cycle opcode and a new stack top must both be dropped
        instr_in = 14'h0008;
        stack_top_in = ~stack_top_in;
        @(posedge sys_clk_in);
        #1;
        chk("pop", stack_pop_out, 1'b0);
        chk("load2", pc_load_out, 1'b0);
        chk("pc_hold", pc_out, ~stack_top_in);
        chk("busy2", busy_out, 1'b0);
      end
      chk("w", w_out, w);
      chk("c", carry_out, c);
    end
    // reset again after the random run
    rst_n_in = 1'b0;
    instr_valid_in = 1'b0;
    @(posedge sys_clk_in);
    #1;
    chk("w_rst2", w_out, 8'h00);
    chk("c_rst2", carry_out, 1'b0);
    rst_n_in = 1'b1;
    stop_test();
  end
endmodule // test_return_and_rotate_execution
`default_nettype wire
